//--- dv/mdu_node.sv
// Far-side node model: sends nine-bit characters and captures the port's own
`timescale 1ns/1ps
`default_nettype none
module mdu_node
    import mdu_pkg::*;
(
    input wire logic clock_in,
    input wire logic txd_in,
    output logic rxd_out,
    output logic cts_b_out,
    output logic [7:0] cap_data_out,
    output logic cap_ninth_out,
    output logic cap_stop_out,
    output logic [7:0] cap_cnt_out
);
    initial
    begin
        rxd_out = 1'b1;
        cts_b_out = 1'b1;
    end

    task set_cts(input logic v);
        cts_b_out <= v;
    endtask : set_cts

    //--------------------------------------------------
    // Sender
    //--------------------------------------------------
    // Start, eight bits LSB first, marker, stop; the line rests high after
    task send_char(input logic mk, input logic [7:0] d);
        logic [10:0] fr;
        fr = {1'b1, mk, d, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            rxd_out <= fr[i];
            repeat (MDU_BIT_CYC) @(posedge clock_in);
        end
    endtask : send_char

    //--------------------------------------------------
    // Capture
    //--------------------------------------------------
    // Samples mid-bit; assumes a ninth bit is always present
    initial
    begin : capture
        logic [9:0] sh;
        cap_data_out = 8'h00;
        cap_ninth_out = 1'b0;
        cap_stop_out = 1'b0;
        cap_cnt_out = 8'h00;
        forever
        begin
            @(posedge clock_in);
            if (txd_in === 1'b0)
            begin
                repeat (MDU_BIT_CYC / 2) @(posedge clock_in);
                for (int k = 0; k < 10; k++)
                begin
                    repeat (MDU_BIT_CYC) @(posedge clock_in);
                    sh[k] = txd_in;
                end
                cap_data_out <= sh[7:0];
                cap_ninth_out <= sh[8];
                cap_stop_out <= sh[9];
                cap_cnt_out <= cap_cnt_out + 8'h01;
            end
        end
    end
endmodule : mdu_node
`default_nettype wire

//--- dv/mdu_port_tb.sv
// Self-checking bench for the multidrop serial port
`timescale 1ns/1ps
`default_nettype none
module mdu_port_tb
    import mdu_pkg::*;
();
    localparam int TIMEOUT = 99000;
    localparam logic [7:0] MATCH_VAL = 8'h3C;
    logic clock_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [11:0] addr_in = 12'h000;
    logic [7:0] wr_data_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] rd_data_out;
    logic rxd_w;
    logic cts_b_w;
    logic txd_out;
    logic rx_event_out;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    int ev_cnt = 0;
    int last_match = 0;
    int n;
    logic [7:0] r;
    logic [7:0] exp_q[$];

    always #2.5 clock_in = ~clock_in;

    mdu_port dut (.clock_in(clock_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
        .rxd_in(rxd_w), .cts_b_in(cts_b_w), .txd_out(txd_out), .rx_event_out(rx_event_out));

    mdu_node node (.clock_in(clock_in), .txd_in(txd_out), .rxd_out(rxd_w),
        .cts_b_out(cts_b_w), .cap_data_out(), .cap_ninth_out(), .cap_stop_out(),
        .cap_cnt_out());

    always @(posedge clock_in)
    begin
        ev_cnt <= ev_cnt + ((rx_event_out === 1'b1) ? 1 : 0);
        cycles <= cycles + 1;
        if (cycles == TIMEOUT)
        begin
            miscompares++;
            end_sim();
        end
    end

    //--------------------------------------------------
    // Tasks
    //--------------------------------------------------
    task end_sim();
        $display("checks=%0d mismatches=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
        begin
            $display("TEST PASSED");
        end
        else
        begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic bus_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clock_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask : bus_wr

    // Read data stands only in the cycle after the strobe edge
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1;
        chk_byte(rd_data_out & m, e);
    endtask : rd_chk

    // Reference filter; every case here runs with addressed mode on
    task automatic rx_case(input logic [1:0] mode, input logic mk, input logic [7:0] d);
        int dlv;
        int e0;
        bus_wr(MDU_CTL1_ADDR, {1'b1, mode, 5'h00});
        if (mk)
        begin
            last_match = (d == MATCH_VAL) ? 1 : 0;
        end
        case (mode)
            2'h0: dlv = 1;
            2'h1: dlv = mk;
            2'h2: dlv = last_match;
            default: dlv = (!mk && last_match != 0) ? 1 : 0;
        endcase
        if (dlv != 0)
        begin
            exp_q.push_back(d);
        end
        e0 = ev_cnt;
        node.send_char(mk, d);
        repeat (8) @(posedge clock_in);
        chk_byte(8'(ev_cnt - e0), 8'(dlv));
        if (dlv != 0)
        begin
            rd_chk(MDU_STAT_ADDR, 8'h89, {1'b1, 6'h00, mk});
            rd_chk(MDU_DATA_ADDR, 8'hFF, exp_q.pop_front());
        end
    endtask : rx_case

    //--------------------------------------------------
    // Main sequence
    //--------------------------------------------------
    initial
    begin
        void'($urandom(20));
        repeat (10) @(posedge clock_in);
        rst_b_in <= 1'b1;
        rd_chk(MDU_CTL0_ADDR, 8'hFF, MDU_CTL0_RST);
        rd_chk(MDU_CTL1_ADDR, 8'hFF, MDU_CTL1_RST);
        rd_chk(MDU_MATCH_ADDR, 8'hFF, MDU_MATCH_RST);
        rd_chk(MDU_STAT_ADDR, 8'hFF, 8'h40);
        r = 8'($urandom());
        bus_wr(MDU_MATCH_ADDR, r);
        rd_chk(MDU_MATCH_ADDR, 8'hFF, r);
        // Transmitter kept off so no character leaves here
        bus_wr(MDU_CTL0_ADDR, r & 8'h1F);
        rd_chk(MDU_CTL0_ADDR, 8'hFF, r & 8'h1F);
        bus_wr(12'hF47, r);
        rd_chk(12'hF47, 8'hFF, 8'h00);
        // Transmit-allowed flag over every enable, gate and handshake setting
        for (int i = 0; i < 8; i++)
        begin
            node.set_cts(i[0]);
            bus_wr(MDU_CTL0_ADDR, {i[2], 1'b1, i[1], 5'h00});
            repeat (4) @(posedge clock_in);
            rd_chk(MDU_STAT_ADDR, 8'h20,
                {2'b00, i[2] & (!i[1] | !i[0]), 5'h00});
        end
        node.set_cts(1'b1);
        bus_wr(MDU_MATCH_ADDR, MATCH_VAL);
        // Character queued with the transmitter off must wait
        bus_wr(MDU_CTL0_ADDR, 8'h78);
        bus_wr(MDU_CTL1_ADDR, 8'hA1);
        bus_wr(MDU_DATA_ADDR, 8'h5B);
        repeat (20) @(posedge clock_in);
        chk_byte({7'h00, txd_out}, 8'h01);
        bus_wr(MDU_CTL0_ADDR, 8'hF8);
        repeat (20) @(posedge clock_in);
        chk_byte({7'h00, txd_out}, 8'h01);
        // Odd parity of 5B would be 0, so a set ninth bit shows the marker won
        fork
            rx_case(2'h1, 1'b1, 8'h21);
            begin
                // Gate dropped with clear-to-send still high; rx_case owns the first cycles
                repeat (4) @(posedge clock_in);
                bus_wr(MDU_CTL0_ADDR, 8'hD8);
                n = 0;
                while (node.cap_cnt_out == 8'h00 && n < 25000)
                begin
                    @(posedge clock_in);
                    n++;
                end
                chk_byte(node.cap_data_out, 8'h5B);
                chk_byte({6'h00, node.cap_ninth_out, node.cap_stop_out}, 8'h03);
            end
        join
        rx_case(2'h3, 1'b1, MATCH_VAL);
        rx_case(2'h2, 1'b0, 8'h55);
        // A foreign frame starts while every byte is taken: back to address-only
        rx_case(2'h0, 1'b1, 8'h12);
        rx_case(2'h1, 1'b0, 8'h77);
        end_sim();
    end
endmodule : mdu_port_tb
`default_nettype wire

//--- include/mdu_pkg.sv
// Constants and types shared by the multidrop serial port files
// Behaviour
// - Ninth bit is address marker in addressed mode
// - Match address bytes against address compare register
// - Addressed mode, filters 10 and 11: deliver only frames for this node
// - Filter mode field selects one of four filters
// - Mode 01: every address byte, never data
// - Mode 00: every byte interrupts, before or after a match
// - Status flag shows byte starts a new frame
// - Control bit 7 enables the transmitter
// - Gate on: start a character only while clear-to-send low
// - Gate off: clear-to-send is ignored
// - Control bit 6 enables the receiver
// - Parity on: add and expect a parity bit
// - Addressed mode overrides parity enable
// - Bit 3 selects even (0) or odd (1)
package mdu_pkg;

    //--------------------------------------------------
    // Register map
    //--------------------------------------------------
    localparam logic [11:0] MDU_CTL0_ADDR = 12'hF42;
    localparam logic [11:0] MDU_CTL1_ADDR = 12'hF43;
    localparam logic [11:0] MDU_STAT_ADDR = 12'hF44;
    localparam logic [11:0] MDU_DATA_ADDR = 12'hF45;
    localparam logic [11:0] MDU_MATCH_ADDR = 12'hF46;
    localparam logic [7:0] MDU_CTL0_RST = 8'h00;
    localparam logic [7:0] MDU_CTL1_RST = 8'h00;
    localparam logic [7:0] MDU_MATCH_RST = 8'h00;

    //--------------------------------------------------
    // Field positions
    //--------------------------------------------------
    localparam int MDU_TX_EN_BIT = 7;
    localparam int MDU_RX_EN_BIT = 6;
    localparam int MDU_CTS_GATE_BIT = 5;
    localparam int MDU_PAR_EN_BIT = 4;
    localparam int MDU_PAR_ODD_BIT = 3;
    localparam int MDU_AMODE_BIT = 7;
    localparam int MDU_FMODE_LSB = 5;
    localparam int MDU_TXMARK_BIT = 0;
    localparam logic [1:0] MDU_FM_EVERY = 2'h0;
    localparam logic [1:0] MDU_FM_ADDR = 2'h1;
    localparam logic [1:0] MDU_FM_MATCH = 2'h2;
    localparam logic [1:0] MDU_FM_DATA = 2'h3;

    //--------------------------------------------------
    // Bit timing
    //--------------------------------------------------
    localparam int MDU_CLK_HZ = 200000000;
    localparam int MDU_BAUD = 115200;
    localparam int MDU_BIT_CYC = MDU_CLK_HZ / MDU_BAUD;
    localparam logic [15:0] MDU_BIT_RELOAD = 16'(MDU_BIT_CYC - 1);
    localparam logic [15:0] MDU_HALF_RELOAD = 16'(MDU_BIT_CYC / 2 - 1);
    localparam logic [3:0] MDU_BITS8 = 4'h8;
    localparam logic [3:0] MDU_BITS9 = 4'h9;

    typedef enum logic [1:0] {MDU_IDLE, MDU_START, MDU_BITS, MDU_STOP} mdu_ser_e;

endpackage : mdu_pkg

//--- verilog/mdu_port.sv
// Multidrop serial port: control registers, transmitter, receive filter
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module mdu_port
    import mdu_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic [11:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rd_data_out,
    input wire logic rxd_in,
    input wire logic cts_b_in,
    output logic txd_out,
    output logic rx_event_out
);

    //--------------------------------------------------
    // State
    //--------------------------------------------------
    typedef struct packed {
        logic [7:0] ctl0;
        logic [7:0] ctl1;
        logic [7:0] match;
        logic [7:0] rx_data;
        logic [7:0] rd_data;
        logic rx_ready;
        logic rx_perr;
        logic rx_ferr;
        logic rx_start;
        logic in_frame;
        logic rx_event;
        logic [1:0] rx_sync;
        logic [1:0] cts_sync;
        logic tx_pend;
        logic [7:0] tx_buf;
        logic tx_mark;
        mdu_ser_e tx_st;
        logic [8:0] tx_sh;
        logic [3:0] tx_cnt;
        logic tx_nine;
        logic [15:0] tx_tmr;
        logic txd;
    } mdu_port_s;

    mdu_port_s s_reg;
    mdu_port_s s_next;

    logic c_valid;
    logic [7:0] c_data;
    logic c_ninth;
    logic c_stop_ok;
    logic amode;
    logic [1:0] fmode;
    logic par_eff;
    logic tx_ok;
    logic tx_start;
    logic c_is_addr;
    logic c_match;
    logic c_par_bad;
    logic deliver;

    //--------------------------------------------------
    // Character receiver
    //--------------------------------------------------
    mdu_rx_char u_rx (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .rx_bit_in(s_reg.rx_sync[1]),
        .enable_in(s_reg.ctl0[MDU_RX_EN_BIT]),
        .ninth_in(amode | par_eff),
        .valid_out(c_valid),
        .data_out(c_data),
        .ninth_out(c_ninth),
        .stop_ok_out(c_stop_ok)
    );

    //--------------------------------------------------
    // Decoded settings
    //--------------------------------------------------
    assign amode = s_reg.ctl1[MDU_AMODE_BIT];
    assign fmode = s_reg.ctl1[MDU_FMODE_LSB +: 2];
    assign par_eff = s_reg.ctl0[MDU_PAR_EN_BIT] & ~amode;
    assign tx_ok = s_reg.ctl0[MDU_TX_EN_BIT] &
                   (~s_reg.ctl0[MDU_CTS_GATE_BIT] | ~s_reg.cts_sync[1]);
    assign tx_start = (s_reg.tx_st == MDU_IDLE) & s_reg.tx_pend & tx_ok;
    assign c_is_addr = amode & c_ninth;
    assign c_match = (c_data == s_reg.match);
    assign c_par_bad = par_eff & (c_ninth != ((^c_data) ^ s_reg.ctl0[MDU_PAR_ODD_BIT]));

    // Filter decision; in filters 10 and 11 data bytes follow the last address seen
    always_comb
    begin
        deliver = 1'b1;
        if (amode)
        begin
            unique case (fmode)
                MDU_FM_EVERY: deliver = 1'b1;
                MDU_FM_ADDR: deliver = c_is_addr;
                MDU_FM_MATCH: deliver = c_is_addr ? c_match : s_reg.in_frame;
                MDU_FM_DATA: deliver = ~c_is_addr & s_reg.in_frame;
            endcase
        end
    end

    //--------------------------------------------------
    // Next state
    //--------------------------------------------------
    always_comb
    begin
        s_next = s_reg;
        s_next.rx_event = 1'b0;
        s_next.rd_data = 8'h00;
        s_next.rx_sync = {s_reg.rx_sync[0], rxd_in};
        s_next.cts_sync = {s_reg.cts_sync[0], cts_b_in};

        if (wr_in)
        begin
            unique case (addr_in)
                MDU_CTL0_ADDR: s_next.ctl0 = wr_data_in;
                MDU_CTL1_ADDR: s_next.ctl1 = wr_data_in;
                MDU_MATCH_ADDR: s_next.match = wr_data_in;
                MDU_DATA_ADDR:
                begin
                    s_next.tx_buf = wr_data_in;
                    s_next.tx_mark = s_reg.ctl1[MDU_TXMARK_BIT];
                    s_next.tx_pend = 1'b1;
                end
                default: ;
            endcase
        end

        if (rd_in)
        begin
            unique case (addr_in)
                MDU_CTL0_ADDR: s_next.rd_data = s_reg.ctl0;
                MDU_CTL1_ADDR: s_next.rd_data = s_reg.ctl1;
                MDU_MATCH_ADDR: s_next.rd_data = s_reg.match;
                MDU_STAT_ADDR: s_next.rd_data = {s_reg.rx_ready,
                    (s_reg.tx_st == MDU_IDLE) & ~s_reg.tx_pend, tx_ok, 1'b0,
                    s_reg.rx_perr, s_reg.rx_ferr, 1'b0, s_reg.rx_start};
                MDU_DATA_ADDR:
                begin
                    s_next.rd_data = s_reg.rx_data;
                    s_next.rx_ready = 1'b0;
                end
                default: s_next.rd_data = 8'h00;
            endcase
        end

        // Receive side; a new byte beats a read that clears ready
        if (c_valid)
        begin
            if (c_is_addr)
            begin
                s_next.in_frame = c_match;
            end
            if (deliver)
            begin
                s_next.rx_data = c_data;
                s_next.rx_ready = 1'b1;
                s_next.rx_perr = c_par_bad;
                s_next.rx_ferr = ~c_stop_ok;
                s_next.rx_start = c_is_addr;
                s_next.rx_event = 1'b1;
            end
        end

        // Transmitter; the gate is checked per character only
        if (s_reg.tx_tmr != 16'h0000)
        begin
            s_next.tx_tmr = s_reg.tx_tmr - 16'h0001;
        end
        unique case (s_reg.tx_st)
            MDU_IDLE:
            begin
                s_next.txd = 1'b1;
                if (tx_start)
                begin
                    // A data write in this same cycle stays pending for the next start
                    s_next.tx_pend = wr_in && (addr_in == MDU_DATA_ADDR);
                    s_next.tx_nine = amode | par_eff;
                    s_next.tx_sh = {amode ? s_reg.tx_mark :
                        (^s_reg.tx_buf) ^ s_reg.ctl0[MDU_PAR_ODD_BIT], s_reg.tx_buf};
                    s_next.tx_cnt = 4'h0;
                    s_next.tx_tmr = MDU_BIT_RELOAD;
                    s_next.txd = 1'b0;
                    s_next.tx_st = MDU_BITS;
                end
            end
            MDU_START:
            begin
                s_next.tx_st = MDU_IDLE;
            end
            MDU_BITS:
            begin
                if (s_reg.tx_tmr == 16'h0000)
                begin
                    s_next.tx_tmr = MDU_BIT_RELOAD;
                    if (s_reg.tx_cnt == (s_reg.tx_nine ? MDU_BITS9 : MDU_BITS8))
                    begin
                        s_next.txd = 1'b1;
                        s_next.tx_st = MDU_STOP;
                    end
                    else
                    begin
                        s_next.txd = s_reg.tx_sh[0];
                        s_next.tx_sh = {1'b0, s_reg.tx_sh[8:1]};
                        s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
                    end
                end
            end
            MDU_STOP:
            begin
                if (s_reg.tx_tmr == 16'h0000)
                begin
                    s_next.tx_st = MDU_IDLE;
                end
            end
        endcase
    end

    //--------------------------------------------------
    // Registers
    //--------------------------------------------------
    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in)
        begin
            s_reg <= '{ctl0: MDU_CTL0_RST, ctl1: MDU_CTL1_RST, match: MDU_MATCH_RST,
                       rx_data: 8'h00, rd_data: 8'h00, rx_ready: 1'b0, rx_perr: 1'b0,
                       rx_ferr: 1'b0, rx_start: 1'b0, in_frame: 1'b0, rx_event: 1'b0,
                       rx_sync: 2'h3, cts_sync: 2'h3, tx_pend: 1'b0, tx_buf: 8'h00,
                       tx_mark: 1'b0, tx_st: MDU_IDLE, tx_sh: 9'h000, tx_cnt: 4'h0,
                       tx_nine: 1'b0, tx_tmr: 16'h0000, txd: 1'b1};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign rd_data_out = s_reg.rd_data;
    assign txd_out = s_reg.txd;
    assign rx_event_out = s_reg.rx_event;

    //--------------------------------------------------
    // Assertions
    //--------------------------------------------------
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_b_in);

    property p_tx_enable;
        (s_reg.tx_st == MDU_IDLE) && s_reg.tx_pend && !s_reg.ctl0[MDU_TX_EN_BIT]
            |=> s_reg.txd && s_reg.tx_pend;
    endproperty
    a_tx_enable: assert property (p_tx_enable)
        else $error("transmitter started while disabled");

    property p_cts_gate;
        tx_start |-> !(s_reg.ctl0[MDU_CTS_GATE_BIT] && s_reg.cts_sync[1]);
    endproperty
    a_cts_gate: assert property (p_cts_gate)
        else $error("transmitter started with clear-to-send high");

    property p_cts_free;
        (s_reg.tx_st == MDU_IDLE) && s_reg.tx_pend && s_reg.ctl0[MDU_TX_EN_BIT]
            && !s_reg.ctl0[MDU_CTS_GATE_BIT] |=> !s_reg.txd ##1 (s_reg.tx_st == MDU_BITS);
    endproperty
    a_cts_free: assert property (p_cts_free)
        else $error("clear-to-send blocked an ungated transmitter");

    property p_rx_off;
        !s_reg.ctl0[MDU_RX_EN_BIT] |-> ##2 !s_reg.rx_event;
    endproperty
    a_rx_off: assert property (p_rx_off)
        else $error("byte delivered with receiver disabled");

    property p_addr_all;
        c_valid && amode && (fmode == MDU_FM_ADDR) |=> s_reg.rx_event == $past(c_ninth);
    endproperty
    a_addr_all: assert property (p_addr_all)
        else $error("address-only filter wrong");

    property p_match;
        c_valid && amode && fmode[1] && c_ninth
            |=> s_reg.in_frame == $past(c_match)
                && s_reg.rx_event == ($past(c_match) && ($past(fmode) == MDU_FM_MATCH));
    endproperty
    a_match: assert property (p_match)
        else $error("address compare filter wrong");

    property p_foreign;
        c_valid && amode && (fmode != MDU_FM_EVERY) && !c_ninth && !s_reg.in_frame
            |=> !s_reg.rx_event;
    endproperty
    a_foreign: assert property (p_foreign)
        else $error("foreign frame data delivered");

    property p_every;
        c_valid && amode && (fmode == MDU_FM_EVERY) |=> s_reg.rx_event && s_reg.rx_ready;
    endproperty
    a_every: assert property (p_every)
        else $error("byte missed in every-byte mode");

    property p_frame_start;
        s_reg.rx_event |-> s_reg.rx_start == $past(c_is_addr);
    endproperty
    a_frame_start: assert property (p_frame_start)
        else $error("frame start flag wrong");

    property p_no_parity;
        s_reg.rx_event && $past(amode) |-> !s_reg.rx_perr;
    endproperty
    a_no_parity: assert property (p_no_parity)
        else $error("parity checked in addressed mode");

    c_match_hit: cover property (c_valid && amode && (fmode == MDU_FM_MATCH) && c_match);
    c_every_byte: cover property (c_valid && amode && (fmode == MDU_FM_EVERY));
    c_cts_wait: cover property (s_reg.tx_pend && s_reg.ctl0[MDU_CTS_GATE_BIT] && !tx_ok);

endmodule : mdu_port
`default_nettype wire

//--- verilog/mdu_rx_char.sv
// Serial character receiver with optional ninth bit
`timescale 1ns/1ps
`default_nettype none
module mdu_rx_char
    import mdu_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic rx_bit_in,
    input wire logic enable_in,
    input wire logic ninth_in,
    output logic valid_out,
    output logic [7:0] data_out,
    output logic ninth_out,
    output logic stop_ok_out
);

    typedef struct packed {
        mdu_ser_e st;
        logic [15:0] tmr;
        logic [3:0] cnt;
        logic nine;
        logic [8:0] sh;
        logic valid;
        logic [7:0] data;
        logic ninth;
        logic stop_ok;
    } mdu_rx_s;

    mdu_rx_s s_reg;
    mdu_rx_s s_next;

    always_comb
    begin
        s_next = s_reg;
        s_next.valid = 1'b0;
        if (s_reg.tmr != 16'h0000)
        begin
            s_next.tmr = s_reg.tmr - 16'h0001;
        end
        unique case (s_reg.st)
            MDU_IDLE:
            begin
                if (!rx_bit_in)
                begin
                    s_next.st = MDU_START;
                    s_next.tmr = MDU_HALF_RELOAD;
                    s_next.nine = ninth_in;
                end
            end
            MDU_START:
            begin
                // Mid start bit high again: a glitch, not a character
                if (s_reg.tmr == 16'h0000)
                begin
                    s_next.st = rx_bit_in ? MDU_IDLE : MDU_BITS;
                    s_next.tmr = MDU_BIT_RELOAD;
                    s_next.cnt = 4'h0;
                end
            end
            MDU_BITS:
            begin
                if (s_reg.tmr == 16'h0000)
                begin
                    s_next.sh = {rx_bit_in, s_reg.sh[8:1]};
                    s_next.cnt = s_reg.cnt + 4'h1;
                    s_next.tmr = MDU_BIT_RELOAD;
                    if (s_next.cnt == (s_reg.nine ? MDU_BITS9 : MDU_BITS8))
                    begin
                        s_next.st = MDU_STOP;
                    end
                end
            end
            MDU_STOP:
            begin
                if (s_reg.tmr == 16'h0000)
                begin
                    s_next.st = MDU_IDLE;
                    s_next.valid = 1'b1;
                    s_next.data = s_reg.nine ? s_reg.sh[7:0] : s_reg.sh[8:1];
                    s_next.ninth = s_reg.nine & s_reg.sh[8];
                    s_next.stop_ok = rx_bit_in;
                end
            end
        endcase
        if (!enable_in)
        begin
            s_next.st = MDU_IDLE;
            s_next.valid = 1'b0;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in)
        begin
            s_reg <= '{st: MDU_IDLE, tmr: 16'h0000, cnt: 4'h0, nine: 1'b0, sh: 9'h000,
                       valid: 1'b0, data: 8'h00, ninth: 1'b0, stop_ok: 1'b0};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign valid_out = s_reg.valid;
    assign data_out = s_reg.data;
    assign ninth_out = s_reg.ninth;
    assign stop_ok_out = s_reg.stop_ok;

endmodule : mdu_rx_char
`default_nettype wire
